// ==== logic/stsr_pkg.sv ====
// constants and field layout of the trim loader
package stsr_pkg;

   // ------------------------------------------------------------
   // frame geometry
   // ------------------------------------------------------------
   localparam int STSR_FRAME_BITS = 58; // meaningful positions held on chip
   localparam int STSR_CNT_BITS = 8; // width of the strobe edge counter
   localparam logic [7:0] STSR_CNT_MAX = 8'hFF; // counter saturates here

   // ------------------------------------------------------------
   // field placement inside the 58-bit register
   // bit 57 is the oldest bit of a frame, bit 0 the newest
   // ------------------------------------------------------------
   localparam int STSR_THIN_TOP = 57; // thin trim bits 5..0, straight slice
   localparam int STSR_THIN_W = 6;
   localparam int STSR_BAL_TOP = 51; // balance bit 0 at top, reversed
   localparam int STSR_BAL_W = 9;
   localparam int STSR_FB_TOP = 42; // feedback bit 0 at top, reversed
   localparam int STSR_FB_W = 10;
   localparam int STSR_GAIN_SEL_POS = 31; // nominal gain select
   localparam int STSR_BW_TOP = 28; // bandwidth bit 0 at top, reversed
   localparam int STSR_BW_W = 4;
   localparam int STSR_REF_SEL_POS = 24; // output reference level select
   localparam int STSR_OFS_TOP = 23; // offset fine trim 4..0, straight slice
   localparam int STSR_OFS_W = 5;
   localparam int STSR_GTRIM_TOP = 18; // gain fine trim 7..0, straight slice
   localparam int STSR_GTRIM_W = 8;
   localparam int STSR_RSVD_TOP = 9; // reserved group 2..0, straight slice
   localparam int STSR_RSVD_W = 3;
   localparam int STSR_QUAD_TOP = 6; // four-bit group bit 0 at top, reversed
   localparam int STSR_QUAD_W = 4;
   localparam int STSR_TRIO_TOP = 2; // three-bit group bit 0 at top, reversed
   localparam int STSR_TRIO_W = 3;

   // ------------------------------------------------------------
   // bandwidth codes and nominal corner in tenths of a kilohertz
   // ------------------------------------------------------------
   localparam logic [3:0] STSR_BW_LAST_CODE = 4'h8; // 1001..1111 unused
   localparam logic [7:0] STSR_BW_TENTHS [0:8] = '{8'h50, 8'h3A, 8'h2A, 8'h1E, 8'h14, 8'h0E, 8'h0A, 8'h08, 8'h05};
   localparam logic [7:0] STSR_BW_UNUSED = 8'h00; // reported for unused codes

   // ------------------------------------------------------------
   // register map, byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] STSR_ADDR_IMAGE_LO = 8'h00; // nonvolatile image 31..0
   localparam logic [7:0] STSR_ADDR_IMAGE_HI = 8'h04; // nonvolatile image 57..32
   localparam logic [7:0] STSR_ADDR_SHIFT_LO = 8'h08; // live register 31..0
   localparam logic [7:0] STSR_ADDR_SHIFT_HI = 8'h0C; // live register 57..32
   localparam logic [7:0] STSR_ADDR_STATUS = 8'h10; // pin levels and strobe edge counter
   localparam logic [7:0] STSR_ADDR_CONTROL = 8'h14; // readout drive enable
   localparam int STSR_HI_W = 26; // bits held in the upper image word

   // status layout
   localparam int STSR_ST_DIRECT = 0; // direct load mode active
   localparam int STSR_ST_BW_OK = 1; // bandwidth code in use
   localparam int STSR_ST_HV = 2; // programming supply pin level
   localparam int STSR_ST_WSEL = 3; // write select pin level seen
   localparam int STSR_ST_CNT_LSB = 8; // strobe edges of this session
   localparam int STSR_ST_BW_LSB = 16; // bandwidth, tenths of kHz

   // reset values
   localparam logic [57:0] STSR_IMAGE_RESET = 58'h0; // blank nonvolatile image
   localparam logic STSR_CTRL_RESET = 1'b1; // readout drive enabled

   // synchroniser lanes
   localparam int STSR_LANES = 5;
   localparam int STSR_LN_DLS = 0;
   localparam int STSR_LN_DATA = 1;
   localparam int STSR_LN_STROBE = 2;
   localparam int STSR_LN_HV = 3;
   localparam int STSR_LN_WSEL = 4;

   // gather a field stored bit 0 first
   function automatic logic [9:0] stsr_pick_reversed(input logic [57:0] r, input int top, input int width);
      logic [9:0] f;
      f = '0;
      for (int k = 0; k < width; k++) begin
         f[k] = r[top - k];
      end
      return f;
   endfunction : stsr_pick_reversed

endpackage : stsr_pkg

// ==== logic/stsr_sync_if.sv ====
// carrier from pin synchroniser to core
`timescale 1ns/1ps
interface stsr_sync_if #(parameter int WIDTH = 5);
   logic [WIDTH-1:0] raw; // unsynchronised pin levels
   logic [WIDTH-1:0] level; // agreed, clean levels

   // synchroniser side
   modport producer (input raw, output level);
   // core side
   modport consumer (output raw, input level);
endinterface : stsr_sync_if

// ==== logic/stsr_pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module stsr_pin_sync import stsr_pkg::*; #(
   parameter int WIDTH = 5,
   parameter logic [WIDTH-1:0] IDLE_LEVEL = '0 // reset level of each lane
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   // pin levels in, clean levels out
   stsr_sync_if.producer pins
);

   // ------------------------------------------------------------
   // stages
   // ------------------------------------------------------------
   logic [WIDTH-1:0] stage_one; // metastable catcher, read only by stage_two
   logic [WIDTH-1:0] stage_two; // first settled copy
   logic [WIDTH-1:0] stage_three; // second settled copy
   logic [WIDTH-1:0] level; // filtered level
   wire [WIDTH-1:0] agree = ~(stage_two ^ stage_three); // lanes stable for two samples
   wire [WIDTH-1:0] next_level = (level & ~agree) | (stage_three & agree);

   // a lane moves once two settled samples match, so a
   // one-cycle strobe glitch makes no false edge
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         stage_one <= IDLE_LEVEL;
         stage_two <= IDLE_LEVEL;
         stage_three <= IDLE_LEVEL;
         level <= IDLE_LEVEL;
      end else begin
         stage_one <= pins.raw;
         stage_two <= stage_one;
         stage_three <= stage_two;
         level <= next_level;
      end
   end

   assign pins.level = level;

endmodule : stsr_pin_sync

// ==== logic/stsr_trim_loader.sv ====
// serial trim shift register with direct load, readout and register port
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module stsr_trim_loader import stsr_pkg::*; #(
   parameter int FRAME_BITS = STSR_FRAME_BITS,
   parameter int ADDR_WIDTH = 8,
   parameter int DATA_WIDTH = 32
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   // serial pins
   input wire logic direct_load_select_in,
   input wire logic serial_input_pin_in,
   input wire logic serial_strobe_in,
   input wire logic high_voltage_program_input_in,
   // write select pin, two-way
   input wire logic write_select_pin_in,
   output logic write_select_pin_out,
   output logic write_select_pin_oe_out,
   // register port
   input wire logic [ADDR_WIDTH-1:0] reg_addr_in,
   input wire logic [DATA_WIDTH-1:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [DATA_WIDTH-1:0] reg_rdata_out,
   // settings applied to the analog path
   output logic [5:0] thin_trim_capacitor_field_out,
   output logic [8:0] balance_capacitor_field_out,
   output logic [9:0] feedback_capacitor_field_out,
   output logic nominal_gain_select_out,
   output logic [3:0] bandwidth_select_out,
   output logic output_reference_level_select_out,
   output logic [4:0] offset_fine_trim_out,
   output logic [7:0] gain_fine_trim_out,
   output logic [2:0] reserved_group_out,
   output logic [3:0] quad_group_out,
   output logic [2:0] trio_group_out,
   output logic bandwidth_code_valid_out
);

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   // only the fixed field layout is served
   if (FRAME_BITS != STSR_FRAME_BITS) begin : g_bad_frame
      $error("frame must be 58 bits");
   end
   if (DATA_WIDTH != 32) begin : g_bad_data
      $error("data width must be 32");
   end
   if (ADDR_WIDTH < 8) begin : g_bad_addr
      $error("address needs 8 bits");
   end

   // ------------------------------------------------------------
   // pin synchronisation
   // ------------------------------------------------------------
   stsr_sync_if #(.WIDTH(STSR_LANES)) pin_bus ();

   assign pin_bus.raw[STSR_LN_DLS] = direct_load_select_in;
   assign pin_bus.raw[STSR_LN_DATA] = serial_input_pin_in;
   assign pin_bus.raw[STSR_LN_STROBE] = serial_strobe_in;
   assign pin_bus.raw[STSR_LN_HV] = high_voltage_program_input_in;
   assign pin_bus.raw[STSR_LN_WSEL] = write_select_pin_in;

   // select pin idles high; a low reset level would fake direct mode
   stsr_pin_sync #(.WIDTH(STSR_LANES), .IDLE_LEVEL(STSR_LANES'(1) << STSR_LN_DLS)) u_sync (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .pins(pin_bus.producer)
   );

   // clean levels; data and strobe share one delay
   wire dls_level = pin_bus.level[STSR_LN_DLS];
   wire data_level = pin_bus.level[STSR_LN_DATA];
   wire strobe_level = pin_bus.level[STSR_LN_STROBE];
   wire hv_level = pin_bus.level[STSR_LN_HV];
   wire wsel_level = pin_bus.level[STSR_LN_WSEL];

   wire direct_mode = ~dls_level; // select pin is active low

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic strobe_prev; // strobe level one cycle back
   logic [57:0] shift_reg; // volatile settings register
   logic [57:0] image; // nonvolatile image, stands in for the array
   logic readout_enable; // software may keep the pin undriven
   logic [STSR_CNT_BITS-1:0] edge_count; // strobe edges this session

   // one strobe rising edge, seen on clean levels
   wire strobe_edge = strobe_level & ~strobe_prev;

   // no length gate: a 60-edge frame pushes
   // its two pads out of the top
   // shift in and out together per edge in direct mode
   wire shift_now = direct_mode & strobe_edge;
   // 58 positions; the newest bit enters at the bottom
   wire [57:0] shifted = {shift_reg[56:0], data_level};

   // outside direct mode the register follows the image
   // so readout shows what was retained
   // in direct mode without an edge the register holds
   wire [57:0] next_shift = ~direct_mode ? image : (shift_now ? shifted : shift_reg);

   // edge count clears outside direct mode
   wire count_full = (edge_count == STSR_CNT_MAX);
   wire [STSR_CNT_BITS-1:0] next_edge_count = ~direct_mode ? '0 :
      ((shift_now && !count_full) ? edge_count + 1'b1 : edge_count);

   // strobe history
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         strobe_prev <= 1'b0;
      end else begin
         strobe_prev <= strobe_level;
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         shift_reg <= STSR_IMAGE_RESET;
      end else begin
         shift_reg <= next_shift;
      end
   end

   // session edge counter
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         edge_count <= '0;
      end else begin
         edge_count <= next_edge_count;
      end
   end

   // ------------------------------------------------------------
   // field decode of the live register
   // ------------------------------------------------------------
   // thin trim 5..0 then balance 0..8
   wire [5:0] dec_thin = shift_reg[STSR_THIN_TOP -: STSR_THIN_W];
   wire [9:0] bal_wide = stsr_pick_reversed(shift_reg, STSR_BAL_TOP, STSR_BAL_W);
   wire [8:0] dec_bal = bal_wide[8:0];
   // feedback 0..9, gain select, bandwidth 0..3; pads are not decoded
   wire [9:0] dec_fb = stsr_pick_reversed(shift_reg, STSR_FB_TOP, STSR_FB_W);
   wire dec_gain_sel = shift_reg[STSR_GAIN_SEL_POS];
   wire [9:0] bw_wide = stsr_pick_reversed(shift_reg, STSR_BW_TOP, STSR_BW_W);
   wire [3:0] dec_bw = bw_wide[3:0];
   // reference select, offset 4..0, gain trim 7..0
   wire dec_ref_sel = shift_reg[STSR_REF_SEL_POS];
   wire [4:0] dec_ofs = shift_reg[STSR_OFS_TOP -: STSR_OFS_W];
   wire [7:0] dec_gtrim = shift_reg[STSR_GTRIM_TOP -: STSR_GTRIM_W];
   // reserved 2..0, four-bit 0..3, three-bit 0..2
   wire [2:0] dec_rsvd = shift_reg[STSR_RSVD_TOP -: STSR_RSVD_W];
   wire [9:0] quad_wide = stsr_pick_reversed(shift_reg, STSR_QUAD_TOP, STSR_QUAD_W);
   wire [3:0] dec_quad = quad_wide[3:0];
   wire [9:0] trio_wide = stsr_pick_reversed(shift_reg, STSR_TRIO_TOP, STSR_TRIO_W);
   wire [2:0] dec_trio = trio_wide[2:0];

   // codes above eight select no filter corner
   wire dec_bw_ok = (dec_bw <= STSR_BW_LAST_CODE);

   // nominal corner of the filter for status reads
   function automatic logic [7:0] bw_tenths(input logic [3:0] code);
      logic [7:0] t;
      t = STSR_BW_UNUSED;
      if (code <= STSR_BW_LAST_CODE) begin
         t = STSR_BW_TENTHS[code];
      end
      return t;
   endfunction : bw_tenths

   wire [7:0] dec_bw_tenths = bw_tenths(dec_bw);

   // settings towards the analog path, one cycle behind
   // the shift register so every output is a flip-flop
   // gain select high means four, low means two, carried as is
   // reference select high means the low offset level
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         thin_trim_capacitor_field_out <= '0;
         balance_capacitor_field_out <= '0;
         feedback_capacitor_field_out <= '0;
         nominal_gain_select_out <= 1'b0;
         bandwidth_select_out <= '0;
         output_reference_level_select_out <= 1'b0;
         offset_fine_trim_out <= '0;
         gain_fine_trim_out <= '0;
         reserved_group_out <= '0;
         quad_group_out <= '0;
         trio_group_out <= '0;
         bandwidth_code_valid_out <= 1'b0;
      end else begin
         thin_trim_capacitor_field_out <= dec_thin;
         balance_capacitor_field_out <= dec_bal;
         feedback_capacitor_field_out <= dec_fb;
         nominal_gain_select_out <= dec_gain_sel;
         bandwidth_select_out <= dec_bw;
         output_reference_level_select_out <= dec_ref_sel;
         offset_fine_trim_out <= dec_ofs;
         gain_fine_trim_out <= dec_gtrim;
         reserved_group_out <= dec_rsvd;
         quad_group_out <= dec_quad;
         trio_group_out <= dec_trio;
         bandwidth_code_valid_out <= dec_bw_ok;
      end
   end

   // ------------------------------------------------------------
   // serial readout on the write select pin
   // ------------------------------------------------------------
   // drive only while direct mode is selected and software allows it
   // the programmer leaves this pin free, so driving it cannot fight
   wire next_wsel_oe = direct_mode & readout_enable;
   // oldest bit is on the pin before the first edge
   // read order is write order less the leading pads
   // bandwidth, reference, offset, gain trim follow in the same order
   // groups come last; after 58 edges fresh input
   // shows as the two trailing pads
   // a reader may stop after 58 edges
   wire next_wsel_data = shift_reg[57];

   // pin register, one cycle behind the shift register,
   // small beside the strobe period
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         write_select_pin_out <= 1'b0;
         write_select_pin_oe_out <= 1'b0;
      end else begin
         write_select_pin_out <= next_wsel_data;
         write_select_pin_oe_out <= next_wsel_oe;
      end
   end

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   wire [7:0] addr_low = reg_addr_in[7:0];
   wire addr_upper_zero = (reg_addr_in >> 8) == '0;
   wire sel_image_lo = addr_upper_zero && (addr_low == STSR_ADDR_IMAGE_LO);
   wire sel_image_hi = addr_upper_zero && (addr_low == STSR_ADDR_IMAGE_HI);
   wire sel_shift_lo = addr_upper_zero && (addr_low == STSR_ADDR_SHIFT_LO);
   wire sel_shift_hi = addr_upper_zero && (addr_low == STSR_ADDR_SHIFT_HI);
   wire sel_status = addr_upper_zero && (addr_low == STSR_ADDR_STATUS);
   wire sel_control = addr_upper_zero && (addr_low == STSR_ADDR_CONTROL);

   // image words; upper word keeps 26 bits
   wire [57:0] next_image = (reg_write_in && sel_image_lo) ? {image[57:32], reg_wdata_in} :
      ((reg_write_in && sel_image_hi) ? {reg_wdata_in[STSR_HI_W-1:0], image[31:0]} : image);
   wire next_readout_enable = (reg_write_in && sel_control) ? reg_wdata_in[0] : readout_enable;

   // status word
   wire [31:0] status_word = {8'h00, dec_bw_tenths, edge_count, 4'h0, wsel_level, hv_level, dec_bw_ok,
      direct_mode};

   // read selection; unmapped addresses read zero
   wire [31:0] read_word = sel_image_lo ? image[31:0] :
      sel_image_hi ? {6'h00, image[57:32]} :
      sel_shift_lo ? shift_reg[31:0] :
      sel_shift_hi ? {6'h00, shift_reg[57:32]} :
      sel_status ? status_word :
      sel_control ? {31'h0, readout_enable} : 32'h0;
   wire [31:0] next_rdata = reg_read_in ? read_word : 32'h0;

   // writable state
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         image <= STSR_IMAGE_RESET;
         readout_enable <= STSR_CTRL_RESET;
      end else begin
         image <= next_image;
         readout_enable <= next_readout_enable;
      end
   end

   // read data stands only in the cycle after the read strobe
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         reg_rdata_out <= '0;
      end else begin
         reg_rdata_out <= next_rdata;
      end
   end

endmodule : stsr_trim_loader

// ==== testbench/stsr_chk.sv ====
// port assertions of the trim loader
`timescale 1ns/1ps
module stsr_chk import stsr_pkg::*; #(
   parameter int ADDR_WIDTH = 8,
   parameter int DATA_WIDTH = 32
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   // serial pins
   input wire logic direct_load_select_in,
   input wire logic serial_strobe_in,
   input wire logic write_select_pin_out,
   input wire logic write_select_pin_oe_out,
   // register port
   input wire logic [ADDR_WIDTH-1:0] reg_addr_in,
   input wire logic [DATA_WIDTH-1:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic [DATA_WIDTH-1:0] reg_rdata_out,
   // decoded bandwidth
   input wire logic [3:0] bandwidth_select_out,
   input wire logic bandwidth_code_valid_out
);
   // ------------------------------------------------------------
   // properties, one clock domain
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   // eight cycles cover sync and output flop
   property p_oe_off; direct_load_select_in [*8] |-> !write_select_pin_oe_out; endproperty
   a_oe_off: assert property (p_oe_off) else $error("oe outside direct");
   property p_oe_ctrl; reg_write_in && reg_addr_in == STSR_ADDR_CONTROL && !reg_wdata_in[0] |=> ##[0:2] !write_select_pin_oe_out; endproperty
   a_oe_ctrl: assert property (p_oe_ctrl) else $error("drive not released");
   property p_rd_idle; !$past(reg_read_in) |-> reg_rdata_out == '0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata without read");
   property p_unmapped; reg_read_in && reg_addr_in == 8'h18 |=> reg_rdata_out == '0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_image_rw; (reg_write_in && reg_addr_in == STSR_ADDR_IMAGE_LO) ##1 !reg_write_in ##1 (reg_read_in && reg_addr_in == STSR_ADDR_IMAGE_LO) |=> reg_rdata_out == $past(reg_wdata_in, 3); endproperty
   a_image_rw: assert property (p_image_rw) else $error("image readback wrong");
   property p_hold; (!serial_strobe_in && !direct_load_select_in) [*8] |-> $stable(write_select_pin_out); endproperty
   a_hold: assert property (p_hold) else $error("pin moved idle");
   property p_bw_ok; !$past(reset_in) |-> bandwidth_code_valid_out == (bandwidth_select_out <= STSR_BW_LAST_CODE); endproperty
   a_bw_ok: assert property (p_bw_ok) else $error("bw flag wrong");
   property p_st_idle; direct_load_select_in [*8] ##0 (reg_read_in && reg_addr_in == STSR_ADDR_STATUS) |=> reg_rdata_out[15:8] == 8'h00 && !reg_rdata_out[0]; endproperty
   a_st_idle: assert property (p_st_idle) else $error("status not idle");
endmodule : stsr_chk

bind stsr_trim_loader stsr_chk #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)) i_chk (
   .ref_clk_in, .reset_in, .direct_load_select_in, .serial_strobe_in, .write_select_pin_out,
   .write_select_pin_oe_out, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
   .bandwidth_select_out, .bandwidth_code_valid_out);

// ==== testbench/stsr_prog_model.sv ====
// programmer: strobes frames, samples the readout wire
`timescale 1ns/1ps
module stsr_prog_model (
   // clock and readout wire
   input wire logic ref_clk_in,
   input wire logic wire_level_in,
   // serial pins
   output logic serial_strobe_out,
   output logic serial_data_out
);
   // ------------------------------------------------------------
   // frame transfer, 400 ns strobe period
   // ------------------------------------------------------------
   logic [59:0] readback; // wire level seen before each edge
   initial begin
      serial_strobe_out = 1'b0;
      serial_data_out = 1'b0;
      readback = '0;
   end
   // one bit per edge, data held 8 cycles
   task automatic send(input logic [59:0] frame, input int first);
      for (int p = first; p < 60; p++) begin
         @(posedge ref_clk_in) serial_strobe_out <= 1'b0;
         serial_data_out <= frame[p];
         repeat (3) @(posedge ref_clk_in);
         #1 readback[p - first] = wire_level_in;
         @(posedge ref_clk_in) serial_strobe_out <= 1'b1;
         repeat (3) @(posedge ref_clk_in);
      end
      @(posedge ref_clk_in) serial_strobe_out <= 1'b0;
      serial_data_out <= 1'b0;
   endtask : send
endmodule : stsr_prog_model

// ==== testbench/tb_top.sv ====
// bench: register port, load and readout
`timescale 1ns/1ps
module tb_top import stsr_pkg::*; ;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic ref_clk_in, reset_in, dls, reg_write, reg_read, strobe, serial_input_pin;
   logic wsel_out, wsel_oe, wsel_last, wsel_wire, bw_ok;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, v;
   logic [53:0] fld; // setting outputs
   logic [57:0] image, live, rb;
   logic [59:0] frame;
   int errors, n_tests, cycles, seed, edges;
   // no pull: a released wire shows its inverse
   assign wsel_wire = wsel_oe ? wsel_out : ~wsel_last;
   stsr_trim_loader i_dut (.ref_clk_in, .reset_in, .direct_load_select_in(dls),
      .serial_input_pin_in(serial_input_pin), .serial_strobe_in(strobe), .high_voltage_program_input_in(1'b0),
      .write_select_pin_in(wsel_wire), .write_select_pin_out(wsel_out), .write_select_pin_oe_out(wsel_oe),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(reg_write), .reg_read_in(reg_read),
      .reg_rdata_out(rdata), .thin_trim_capacitor_field_out(fld[53:48]), .balance_capacitor_field_out(fld[47:39]),
      .feedback_capacitor_field_out(fld[38:29]), .nominal_gain_select_out(fld[28]),
      .bandwidth_select_out(fld[27:24]), .output_reference_level_select_out(fld[23]),
      .offset_fine_trim_out(fld[22:18]), .gain_fine_trim_out(fld[17:10]), .reserved_group_out(fld[9:7]),
      .quad_group_out(fld[6:3]), .trio_group_out(fld[2:0]), .bandwidth_code_valid_out(bw_ok));
   stsr_prog_model i_prog (.ref_clk_in, .wire_level_in(wsel_wire), .serial_strobe_out(strobe),
      .serial_data_out(serial_input_pin));
   // ------------------------------------------------------------
   // clock, wire memory, hang guard (20000 cycles)
   // ------------------------------------------------------------
   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (wsel_oe === 1'b1) wsel_last <= wsel_out;
      if (cycles == 20000) begin
         errors++;
         results();
      end
   end
   // ------------------------------------------------------------
   // tasks and expectations
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in) addr <= a;
      wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk_in) reg_write <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk_in) addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk_in) reg_read <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   // expected settings, packed like fld
   function automatic logic [53:0] exp_fields(input logic [59:0] f);
      logic [5:0] th;
      logic [4:0] of;
      logic [7:0] gt;
      logic [2:0] rs;
      th = {<<{f[7:2]}};
      of = {<<{f[40:36]}};
      gt = {<<{f[48:41]}};
      rs = {<<{f[52:50]}};
      return {th, f[16:8], f[26:17], f[28], f[34:31], f[35], of, gt, rs, f[56:53], f[59:57]};
   endfunction : exp_fields
   task automatic results();
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      seed = 32'h5218e520;
      reset_in = 1'b1;
      dls = 1'b1;
      reg_write = 1'b0;
      reg_read = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      wsel_last = 1'b0;
      repeat (5) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      rd_reg(STSR_ADDR_CONTROL, v);
      chk("control", STSR_CTRL_RESET, v);
      image = 58'({$random(seed), $random(seed)});
      wr_reg(STSR_ADDR_IMAGE_LO, image[31:0]);
      rd_reg(STSR_ADDR_IMAGE_LO, v);
      chk("image_lo", image[31:0], v);
      wr_reg(STSR_ADDR_IMAGE_HI, 32'(image[57:32]));
      rd_reg(STSR_ADDR_IMAGE_HI, v);
      chk("image_hi", image[57:32], v);
      // read-only ignores writes; unmapped reads zero
      wr_reg(STSR_ADDR_SHIFT_LO, ~image[31:0]);
      rd_reg(STSR_ADDR_SHIFT_LO, v);
      chk("shift_lo", image[31:0], v);
      rd_reg(8'h18, v);
      chk("unmapped", 64'h0, v);
      rd_reg(STSR_ADDR_STATUS, v);
      chk("status", 64'h0, {v[15:8], v[0]});
      dls <= 1'b0;
      repeat (8) @(posedge ref_clk_in);
      live = image;
      edges = 0;
      // 60 and 58 edge frames; codes 8 and 9 last
      for (int i = 0; i < 4; i++) begin
         frame = 60'({$random(seed), $random(seed)});
         if (i > 1) frame[34:31] = (i == 2) ? 4'h8 : 4'h9;
         i_prog.send(frame, (i % 2) * 2);
         edges += 60 - (i % 2) * 2;
         repeat (8) @(posedge ref_clk_in);
         rb = {<<{live}};
         chk("readback", rb, i_prog.readback[57:0]);
         if (i % 2 == 0) chk("read_pads", frame[1:0], i_prog.readback[59:58]);
         live = {<<{frame[59:2]}};
         rd_reg(STSR_ADDR_SHIFT_LO, v);
         chk("live_lo", live[31:0], v);
         rd_reg(STSR_ADDR_SHIFT_HI, v);
         chk("live_hi", live[57:32], v);
         chk("fields", exp_fields(frame), fld);
         chk("bw_ok", frame[34:31] <= 4'h8, bw_ok);
         rd_reg(STSR_ADDR_STATUS, v);
         chk("edges", edges, v[15:8]);
         chk("corner", frame[34:31] <= 4'h8 ? STSR_BW_TENTHS[frame[34:31]] : STSR_BW_UNUSED, v[23:16]);
      end
      // select high: strobes ignored, image returns
      dls <= 1'b1;
      repeat (8) @(posedge ref_clk_in);
      i_prog.send(~frame, 2);
      rd_reg(STSR_ADDR_SHIFT_HI, v);
      chk("follow", image[57:32], v);
      wr_reg(STSR_ADDR_CONTROL, 32'h0);
      dls <= 1'b0;
      repeat (8) @(posedge ref_clk_in);
      chk("drive_off", 64'h0, wsel_oe);
      results();
   end
endmodule : tb_top
